// [slc_limiter_ctrl.sv]
// Register file and mode logic of the stereo output limiter.
// Assumes a battery code and a sample tick from logic on i_clk.
//
// Function
// - Left threshold code bits 7:3, 16V..2V
// - Left slope bits 1:0, ratios 1:1..4:1
// - Left battery knee, 8-bit, reset 0x22
// - Right release rate bits 7:6, reset 2
// - Right attack rate bits 5:4, reset 2
// - Link bit 3: right follows left settings
// - Tracking off: fixed right threshold used
// - Tracking on: threshold falls below knee
// - Right mode: off, on, mute below knee
// - Mode 3: limiter on only below knee
// - Reset values 0x51 and 0xA8
// - Right threshold and slope at 0x12
// - Right battery knee at 0x13, reset 0x22
// - Left has own tracking and mode
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "slc_consts.svh"

module slc_limiter_ctrl
  import slc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_clk_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_sample_tick,
  input  wire logic [7:0] i_vbat_code,
  output logic      [7:0] o_rdata,
  output slc_chan_t       o_left,
  output slc_chan_t       o_right
);

  // ========================================================================
  // Functions

  // Threshold code to quarter volts
  function automatic logic [6:0] thr_qv(input logic [4:0] code);
    logic [6:0] c;
    c = {2'h0, code};
    if (code <= `SLC_THR_FINE_START)
    begin
      thr_qv = `SLC_THR_TOP_QV - (c << 1);
    end
    else if (code <= `SLC_THR_FINE_END)
    begin
      thr_qv = 7'h33 - c;
    end
    else
    begin
      thr_qv = 7'h46 - (c << 1);
    end
  endfunction

  // Battery under the knee, unsigned codes on one scale
  function automatic logic below_knee(
    input logic [7:0] vbat,
    input logic [7:0] knee
  );
    below_knee = vbat < knee;
  endfunction

  // Shortfall under the knee; zero once the live code recovers
  function automatic logic [7:0] knee_deficit(
    input logic [7:0] knee,
    input logic [7:0] vbat
  );
    if (below_knee(vbat, knee))
    begin
      knee_deficit = knee - vbat;
    end
    else
    begin
      // Live code may rise above the knee before the next tick
      knee_deficit = 8'h00;
    end
  endfunction

  // Fixed or battery tracked threshold
  function automatic logic [6:0] eff_thr(
    input slc_cfg_t   cfg,
    input logic       below,
    input logic [7:0] vbat
  );
    logic [6:0] base;
    logic [7:0] deficit;
    logic [9:0] drop;
    base    = thr_qv(cfg.threshold_code);
    deficit = knee_deficit(cfg.knee, vbat);
    drop    = 10'(deficit) * (10'(cfg.slope) + 10'h001);
    if (!cfg.track || !below)
    begin
      eff_thr = base;
    end
    else if (drop >= 10'(base) - 10'(`SLC_THR_FLOOR_QV))
    begin
      // Never below the lowest table entry
      eff_thr = `SLC_THR_FLOOR_QV;
    end
    else
    begin
      eff_thr = base - drop[6:0];
    end
  endfunction

  // Settings and battery flag to channel controls
  function automatic slc_chan_t chan_ctl(
    input slc_cfg_t   cfg,
    input logic       below,
    input logic [7:0] vbat
  );
    slc_chan_t r;
    r.attack_rate  = cfg.attack_rate;
    r.release_rate = cfg.release_rate;
    r.threshold_qv = eff_thr(cfg, below, vbat);
    r.limit_en     = 1'b0;
    r.mute         = 1'b0;
    unique case (cfg.mode)
      SLC_MODE_OFF:
      begin
        r.limit_en = 1'b0;
      end
      SLC_MODE_ON:
      begin
        r.limit_en = 1'b1;
      end
      SLC_MODE_MUTE_LOW:
      begin
        r.mute = below;
      end
      SLC_MODE_ON_LOW:
      begin
        r.limit_en = below;
      end
    endcase
    chan_ctl = r;
  endfunction

  // Masked register write
  function automatic logic [7:0] wr_reg(
    input logic [7:0] cur,
    input logic [7:0] data,
    input logic [7:0] mask
  );
    wr_reg = (cur & ~mask) | (data & mask);
  endfunction

  // Read mux; unmapped addresses and reserved bits read zero
  function automatic logic [7:0] reg_rd(
    input logic [7:0] addr,
    input slc_state_t st
  );
    unique case (addr)
      `SLC_ADDR_L_CTRL1:
      begin
        reg_rd = st.left_limit_ctrl1;
      end
      `SLC_ADDR_L_THR_SLOPE:
      begin
        reg_rd = st.left_limit_threshold_slope;
      end
      `SLC_ADDR_L_KNEE:
      begin
        reg_rd = st.left_limit_battery_knee;
      end
      `SLC_ADDR_R_RATES_MODE:
      begin
        reg_rd = st.right_limit_rates_mode;
      end
      `SLC_ADDR_R_THR_SLOPE:
      begin
        reg_rd = st.right_limit_threshold_slope;
      end
      `SLC_ADDR_R_KNEE:
      begin
        reg_rd = st.right_limit_battery_knee;
      end
      default:
      begin
        reg_rd = 8'h00;
      end
    endcase
  endfunction

  // ========================================================================
  // State

  slc_state_t state_q;
  slc_state_t state_d;
  slc_cfg_t   left_cfg;
  slc_cfg_t   right_cfg;
  slc_cfg_t   right_use;
  logic       right_use_below;

  // ========================================================================
  // Settings decode

  always_comb
  begin
    left_cfg.release_rate   =
      state_q.left_limit_ctrl1[`SLC_RELEASE_MSB:`SLC_RELEASE_LSB];
    left_cfg.attack_rate    =
      state_q.left_limit_ctrl1[`SLC_ATTACK_MSB:`SLC_ATTACK_LSB];
    left_cfg.track          = state_q.left_limit_ctrl1[`SLC_TRACK_BIT];
    left_cfg.mode           =
      slc_mode_t'(state_q.left_limit_ctrl1[`SLC_MODE_MSB:`SLC_MODE_LSB]);
    left_cfg.threshold_code =
      state_q.left_limit_threshold_slope[`SLC_THR_MSB:`SLC_THR_LSB];
    left_cfg.slope          =
      state_q.left_limit_threshold_slope[`SLC_SLOPE_MSB:`SLC_SLOPE_LSB];
    left_cfg.knee           = state_q.left_limit_battery_knee;

    right_cfg.release_rate   =
      state_q.right_limit_rates_mode[`SLC_RELEASE_MSB:`SLC_RELEASE_LSB];
    right_cfg.attack_rate    =
      state_q.right_limit_rates_mode[`SLC_ATTACK_MSB:`SLC_ATTACK_LSB];
    right_cfg.track          = state_q.right_limit_rates_mode[`SLC_TRACK_BIT];
    right_cfg.mode           =
      slc_mode_t'(state_q.right_limit_rates_mode[`SLC_MODE_MSB:`SLC_MODE_LSB]);
    right_cfg.threshold_code =
      state_q.right_limit_threshold_slope[`SLC_THR_MSB:`SLC_THR_LSB];
    right_cfg.slope          =
      state_q.right_limit_threshold_slope[`SLC_SLOPE_MSB:`SLC_SLOPE_LSB];
    right_cfg.knee           = state_q.right_limit_battery_knee;

    // Linked: one limiter, left controls drive both outputs
    if (state_q.right_limit_rates_mode[`SLC_LINK_BIT])
    begin
      right_use       = left_cfg;
      right_use_below = state_q.left_below;
    end
    else
    begin
      right_use       = right_cfg;
      right_use_below = state_q.right_below;
    end
  end

  // ========================================================================
  // Next state

  always_comb
  begin
    state_d       = state_q;
    state_d.rdata = 8'h00;

    // Register writes
    if (i_wr)
    begin
      unique case (i_addr)
        `SLC_ADDR_L_CTRL1:
        begin
          state_d.left_limit_ctrl1 = wr_reg(state_q.left_limit_ctrl1, i_wdata,
                                            `SLC_WMASK_L_CTRL1);
        end
        `SLC_ADDR_L_THR_SLOPE:
        begin
          state_d.left_limit_threshold_slope =
            wr_reg(state_q.left_limit_threshold_slope, i_wdata,
                   `SLC_WMASK_THR_SLOPE);
        end
        `SLC_ADDR_L_KNEE:
        begin
          state_d.left_limit_battery_knee = i_wdata;
        end
        `SLC_ADDR_R_RATES_MODE:
        begin
          state_d.right_limit_rates_mode = i_wdata;
        end
        `SLC_ADDR_R_THR_SLOPE:
        begin
          state_d.right_limit_threshold_slope =
            wr_reg(state_q.right_limit_threshold_slope, i_wdata,
                   `SLC_WMASK_THR_SLOPE);
        end
        `SLC_ADDR_R_KNEE:
        begin
          state_d.right_limit_battery_knee = i_wdata;
        end
        default:
        begin
          // Unmapped writes are dropped
          state_d.rdata = 8'h00;
        end
      endcase
    end

    // Register reads, data valid in the next cycle only
    if (i_rd)
    begin
      state_d.rdata = reg_rd(i_addr, state_q);
    end

    // Battery compare once per sample; avoids flicker mid-sample
    if (i_sample_tick)
    begin
      state_d.left_below  = below_knee(i_vbat_code, state_q.left_limit_battery_knee);
      state_d.right_below = below_knee(i_vbat_code, state_q.right_limit_battery_knee);
    end

    // Channel controls
    state_d.left_out  = chan_ctl(left_cfg, state_q.left_below, i_vbat_code);
    state_d.right_out = chan_ctl(right_use, right_use_below, i_vbat_code);
  end

  // ========================================================================
  // Registers

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q                             <= '0;
      state_q.left_limit_ctrl1            <= `SLC_RST_L_CTRL1;
      state_q.left_limit_threshold_slope  <= `SLC_RST_THR_SLOPE;
      state_q.left_limit_battery_knee     <= `SLC_RST_KNEE;
      state_q.right_limit_rates_mode      <= `SLC_RST_R_RATES_MODE;
      state_q.right_limit_threshold_slope <= `SLC_RST_THR_SLOPE;
      state_q.right_limit_battery_knee    <= `SLC_RST_KNEE;
    end
    else if (i_clk_en)
    begin
      state_q <= state_d;
    end
  end

  // ========================================================================
  // Outputs

  assign o_rdata = state_q.rdata;
  assign o_left  = state_q.left_out;
  assign o_right = state_q.right_out;

endmodule
`default_nettype wire

// [slc_consts.svh]
// Constants of the stereo limiter control block: offsets, resets, fields.
// Assumes nothing; included by the design module.
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH

// ==========================================================================
// Register offsets
`define SLC_ADDR_L_CTRL1      8'h0E
`define SLC_ADDR_L_THR_SLOPE  8'h0F
`define SLC_ADDR_L_KNEE       8'h10
`define SLC_ADDR_R_RATES_MODE 8'h11
`define SLC_ADDR_R_THR_SLOPE  8'h12
`define SLC_ADDR_R_KNEE       8'h13

// ==========================================================================
// Reset values
`define SLC_RST_L_CTRL1       8'hA0
`define SLC_RST_THR_SLOPE     8'h51
`define SLC_RST_KNEE          8'h22
`define SLC_RST_R_RATES_MODE  8'hA8

// ==========================================================================
// Writable bits; reserved bits stay zero
`define SLC_WMASK_L_CTRL1     8'hF7
`define SLC_WMASK_THR_SLOPE   8'hFB
`define SLC_WMASK_FULL        8'hFF

// ==========================================================================
// Field positions
`define SLC_RELEASE_MSB       7
`define SLC_RELEASE_LSB       6
`define SLC_ATTACK_MSB        5
`define SLC_ATTACK_LSB        4
`define SLC_LINK_BIT          3
`define SLC_TRACK_BIT         2
`define SLC_MODE_MSB          1
`define SLC_MODE_LSB          0
`define SLC_THR_MSB           7
`define SLC_THR_LSB           3
`define SLC_SLOPE_MSB         1
`define SLC_SLOPE_LSB         0

// ==========================================================================
// Threshold table, in quarter volts
`define SLC_THR_TOP_QV        7'h40
`define SLC_THR_FINE_START    5'h0D
`define SLC_THR_FINE_END      5'h13
`define SLC_THR_FLOOR_QV      7'h08

`endif

// [slc_pkg.sv]
// Types of the stereo limiter control block.
// Assumes the constants header is on the include path.
package slc_pkg;

  // ========================================================================
  // Limiter modes
  typedef enum logic [1:0] {
    SLC_MODE_OFF      = 2'h0,
    SLC_MODE_ON       = 2'h1,
    SLC_MODE_MUTE_LOW = 2'h2,
    SLC_MODE_ON_LOW   = 2'h3
  } slc_mode_t;

  // ========================================================================
  // Decoded settings of one limiter
  typedef struct packed {
    logic [1:0] release_rate;
    logic [1:0] attack_rate;
    logic       track;
    slc_mode_t  mode;
    logic [4:0] threshold_code;
    logic [1:0] slope;
    logic [7:0] knee;
  } slc_cfg_t;

  // ========================================================================
  // Controls handed to one channel's limiter datapath
  typedef struct packed {
    logic       limit_en;
    logic       mute;
    logic [6:0] threshold_qv;
    logic [1:0] attack_rate;
    logic [1:0] release_rate;
  } slc_chan_t;

  // ========================================================================
  // Whole state of the block
  typedef struct packed {
    logic [7:0] left_limit_ctrl1;
    logic [7:0] left_limit_threshold_slope;
    logic [7:0] left_limit_battery_knee;
    logic [7:0] right_limit_rates_mode;
    logic [7:0] right_limit_threshold_slope;
    logic [7:0] right_limit_battery_knee;
    logic [7:0] rdata;
    logic       left_below;
    logic       right_below;
    slc_chan_t  left_out;
    slc_chan_t  right_out;
  } slc_state_t;

endpackage

// [slc_limiter_ctrl_properties.sv]
// Checker of the limiter control ports: register bus and right modes.
// Assumes a bind to every slc_limiter_ctrl instance, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module slc_limiter_ctrl_props
  import slc_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       i_clk_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire slc_chan_t  o_right
);
  logic [7:0] wd1_q;
  logic [7:0] wd2_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // Write data two edges back, for read-back and rate checks
  always_ff @(posedge i_clk)
  begin
    wd1_q <= i_wdata;
    wd2_q <= wd1_q;
  end

  // ========
  // Sequences
  sequence s_wr(a);
    i_clk_en && i_wr && i_addr == a;
  endsequence
  sequence s_rd(a);
    i_clk_en && i_rd && i_addr == a;
  endsequence
  // Unlinked right write, then a quiet cycle so the output can settle
  sequence s_wr_r(m);
    i_clk_en && i_wr && i_addr == 8'h11 && !i_wdata[3] && i_wdata[1:0] == m
      ##1 i_clk_en && !i_wr;
  endsequence

  // ========
  // Assertions
  AST_RDATA_IDLE: assert property ((i_clk_en && !i_rd) |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property ((i_clk_en && i_rd && (i_addr < 8'h0E || i_addr > 8'h13))
    |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RESERVED: assert property ((i_clk_en && i_rd && (i_addr == 8'h0F || i_addr == 8'h12))
    |=> o_rdata[2] == 1'b0)
    else $error("reserved bit reads one");
  AST_READBACK: assert property (s_wr(8'h13) ##1 s_rd(8'h13) |=> o_rdata == wd2_q)
    else $error("knee read-back differs");
  AST_MODE_OFF: assert property (s_wr_r(2'h0) |=> !o_right.limit_en && !o_right.mute)
    else $error("mode off not honoured");
  AST_MODE_ON: assert property (s_wr_r(2'h1) |=> o_right.limit_en
    && o_right.attack_rate == wd2_q[5:4] && o_right.release_rate == wd2_q[7:6])
    else $error("mode on or rates wrong");
  AST_MODE_MUTE: assert property (s_wr_r(2'h2) |=> !o_right.limit_en)
    else $error("mute mode enables limiter");
  AST_MODE_LOW: assert property (s_wr_r(2'h3) |=> !o_right.mute)
    else $error("low-battery mode mutes");
endmodule

bind slc_limiter_ctrl slc_limiter_ctrl_props u_props (.i_clk, .i_arst_n, .i_clk_en,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_right);
`default_nettype wire

// [slc_limiter_ctrl_tb_top.sv]
// Self-checking bench of the limiter control block.
// Assumes package, header, design and checker compiled before it.
`timescale 1ns/10ps
`default_nettype none
module slc_limiter_ctrl_tb_top;
  import slc_pkg::*;
  logic       i_clk;
  logic       i_arst_n;
  logic       i_clk_en;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic       i_sample_tick;
  logic [7:0] i_vbat_code;
  logic [7:0] o_rdata;
  slc_chan_t  o_left;
  slc_chan_t  o_right;
  int         n_mismatch;
  int         check_count;
  logic [7:0] rst_v [6] = '{8'hA0, 8'h51, 8'h22, 8'hA8, 8'h51, 8'h22};
  int         codes [7] = '{0, 1, 13, 14, 19, 20, 31};

  slc_limiter_ctrl dut (.i_clk, .i_arst_n, .i_clk_en, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_sample_tick, .i_vbat_code, .o_rdata, .o_left, .o_right);

  // ========
  // Helpers
  function automatic logic [6:0] thq(int c);
    thq = 7'(c <= 13 ? 64 - 2 * c : c <= 19 ? 38 - (c - 13) : 32 - 2 * (c - 19));
  endfunction
  function automatic slc_chan_t exp_ch(int m, int b, int th, int at, int rl);
    exp_ch = {m == 1 || (m == 3 && b == 1), m == 2 && b == 1, 7'(th), 2'(at), 2'(rl)};
  endfunction
  task automatic cmp_reg(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_ch(string nm, slc_chan_t e, slc_chan_t g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Tasks end 1 ns past the edge, so back-to-back strobes never collide
  task automatic wr(logic [7:0] a, logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    cmp_reg("rdata", e, o_rdata);
  endtask
  task automatic tick(logic [7:0] v);
    i_vbat_code <= v;
    i_sample_tick <= 1'b1;
    @(posedge i_clk);
    i_sample_tick <= 1'b0;
    #1;
  endtask
  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ========
  // Clock, watchdog, tests
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    {i_arst_n, i_wr, i_rd, i_sample_tick, i_addr, i_wdata} = '0;
    i_clk_en = 1'b1;
    i_vbat_code = 8'h30;
    n_mismatch = 0;
    check_count = 0;
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    foreach (rst_v[i]) rd(8'(8'h0E + i), rst_v[i]);
    cmp_ch("left", exp_ch(0, 0, 44, 2, 2), o_left);
    cmp_ch("right", exp_ch(0, 0, 44, 2, 2), o_right);
    rd(8'h0D, 8'h00);
    rd(8'h14, 8'h00);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, 8'hFB);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'hFB);
    wr(8'h10, 8'h3C);
    rd(8'h10, 8'h3C);
    wr(8'h13, 8'h5A);
    rd(8'h13, 8'h5A);
    // Frozen clock enable must drop the write
    i_clk_en <= 1'b0;
    wr(8'h13, 8'h22);
    i_clk_en <= 1'b1;
    rd(8'h13, 8'h5A);
    wr(8'h13, 8'h22);
    rd(8'h13, 8'h22);
    wr(8'h12, 8'h51);
    $display("test registers done");
    for (int b = 0; b < 2; b++)
    begin
      tick(b ? 8'h20 : 8'h30);
      for (int m = 0; m < 4; m++)
      begin
        wr(8'h11, 8'(8'h70 + m));
        settle();
        cmp_ch("right", exp_ch(m, b, 44, 3, 1), o_right);
      end
    end
    $display("test modes done");
    wr(8'h11, 8'h71);
    foreach (codes[i])
    begin
      wr(8'h12, 8'(codes[i] * 8 + 1));
      settle();
      cmp_ch("right", exp_ch(1, 0, thq(codes[i]), 3, 1), o_right);
    end
    // Battery 0x20 sits two codes under the 0x22 knee
    wr(8'h11, 8'h75);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h12, 8'(8'h50 + s));
      settle();
      cmp_ch("right", exp_ch(1, 0, 44 - 2 * (s + 1), 3, 1), o_right);
    end
    // Live code back above the knee before the next tick: no reduction
    i_vbat_code <= 8'h30;
    settle();
    cmp_ch("right", exp_ch(1, 0, 44, 3, 1), o_right);
    i_vbat_code <= 8'h20;
    wr(8'h12, 8'hFB);
    settle();
    cmp_ch("right", exp_ch(1, 0, 8, 3, 1), o_right);
    $display("test threshold done");
    wr(8'h0E, 8'h51);
    wr(8'h0F, 8'h21);
    wr(8'h11, 8'h08);
    settle();
    cmp_ch("left", exp_ch(1, 1, 56, 1, 1), o_left);
    cmp_ch("right", exp_ch(1, 1, 56, 1, 1), o_right);
    wr(8'h0E, 8'h53);
    settle();
    cmp_ch("right", exp_ch(3, 1, 56, 1, 1), o_right);
    $display("test link done");
    wrap_up();
  end
endmodule
`default_nettype wire
